// *** shared/audio_clk_defs.vh ***
`ifndef AUDIO_CLK_DEFS_VH
`define AUDIO_CLK_DEFS_VH

// register offsets
`define ADDR_RATE_RATIO_CFG   8'h14
`define ADDR_DETECT_STATUS    8'h15
`define ADDR_ROOT_SRC_CFG     8'h16

// reset values
`define RST_RATE_RATIO_CFG    8'h48
`define RST_DETECT_STATUS     8'hFF
`define RST_ROOT_SRC_CFG      8'h10

// field positions
`define FRAME_RATE_MSB        7
`define FRAME_RATE_LSB        4
`define BITCLK_RATIO_MSB      3
`define BITCLK_RATIO_LSB      0
`define ROOT_SEL_BIT          7
`define SPEC_MODE_BIT         6
`define MCLK_RATIO_MSB        5
`define MCLK_RATIO_LSB        3
`define ROOT_SRC_WR_MASK      8'hF8

// code limits
`define RATE_CODE_MAX         4'h8
`define RATIO_CODE_MAX        4'hC
`define CODE_INVALID          4'hF

// detection timing, core clock 10 MHz
`define CORE_CLK_KHZ          10000
`define SLOWEST_RATE_HZ       7350
`define FRAME_TIMEOUT_CYC     12'hFFF

// frame period windows in core cycles, both rate families
`define PER_C0_LO 12'h4BC
`define PER_C0_HI 12'h579
`define PER_C1_LO 12'h25E
`define PER_C1_HI 12'h2BC
`define PER_C2_LO 12'h194
`define PER_C2_HI 12'h1D3
`define PER_C3_LO 12'h12F
`define PER_C3_HI 12'h15E
`define PER_C4_LO 12'h0CA
`define PER_C4_HI 12'h0E9
`define PER_C5_LO 12'h065
`define PER_C5_HI 12'h075
`define PER_C6_LO 12'h032
`define PER_C6_HI 12'h03A
`define PER_C7_LO 12'h019
`define PER_C7_HI 12'h01D
`define PER_C8_LO 12'h00C
`define PER_C8_HI 12'h00F

`endif

// *** rtl/pin_edge_sync.v ***
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser; edges are taken from the second and third flops
module pin_edge_sync (
	input  wire i_core_clk,
	input  wire i_resetn,
	input  wire i_pin,
	output wire o_level,
	output wire o_rise,
	output wire o_fall
);
	reg meta_q;
	reg sync_q;
	reg last_q;

	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign o_level = sync_q;
	assign o_rise  = sync_q & ~last_q;
	assign o_fall  = ~sync_q & last_q;
endmodule

`default_nettype wire

// *** rtl/audio_serial_clock_config_monitor.v ***
// Behaviour
// R01 - rate field bits 7:4 picks frame rate codes 0..8, 9..15 reserved
// R02 - ratio field bits 3:0 picks bit clock ratio 16..2048, reset 256
// R03 - slave with automatic configuration ignores both programmed fields
// R04 - measured frame rate reported read-only, same codes, resets to all ones
// R05 - unsupported measured rate reads 15, codes 9..14 never reported
// R06 - measured ratio reported read-only, resets all ones, 15 means invalid
// R07 - slave auto no-PLL: select bit 0 root is bit clock, 1 master clock
// R08 - spec mode bit: 0 absolute master clock frequency, 1 multiple of rate; code uses absolute whenever auto configuration is off
// R09 - master clock ratio field bits 5:3, 64..2304, resets to code 2
// R10 - master clock ratio used in master mode or when it is root source
// R11 - rate/ratio register resets to 48 hex
// R12 - source register resets to 10 hex, low bits read zero; status FF
// R13 - slave: partner drives bit clock and frame sync; master: device drives
// R14 - pll disable input in auto configuration enables the root select
// R15 - family select picks 48 kHz (0) or 44.1 kHz (1) multiples
// R16 - absolute master clock select codes 12 to 24.576 MHz
// R17 - continuously measure, publish only stable supported values
`timescale 1ns/1ps
`default_nettype none
`include "audio_clk_defs.vh"

module audio_serial_clock_config_monitor (
	input  wire       i_core_clk,
	input  wire       i_resetn,
	input  wire [7:0] i_reg_addr,
	input  wire [7:0] i_reg_wdata,
	input  wire       i_reg_wr_en,
	output reg  [7:0] o_reg_rdata,
	input  wire       i_bus_role_select,
	input  wire       i_auto_config_disable,
	input  wire       i_auto_config_pll_disable,
	input  wire       i_rate_family_select,
	input  wire [2:0] i_master_clock_frequency_select,
	input  wire       i_master_clock,
	input  wire       i_bitclk,
	output wire       o_bitclk,
	output wire       o_bitclk_oe_n,
	input  wire       i_frame_sync,
	output wire       o_frame_sync,
	output wire       o_frame_sync_oe_n,
	output wire       o_root_from_master_clock,
	output wire       o_master_clock_ratio_in_use
);
	// ---------------- registers ----------------
	reg  [7:0] rate_ratio_q;
	reg  [7:0] root_src_q;
	reg  [3:0] det_rate_q;
	reg  [3:0] det_ratio_q;

	wire [3:0] programmed_frame_rate;
	wire [3:0] programmed_bitclk_frame_ratio;
	wire       no_pll_root_clock_select;
	wire       master_clock_spec_mode;
	wire [2:0] master_clock_ratio_code;
	wire       auto_on;

	assign programmed_frame_rate         =
		rate_ratio_q[`FRAME_RATE_MSB:`FRAME_RATE_LSB];           // [R01]
	assign programmed_bitclk_frame_ratio =
		rate_ratio_q[`BITCLK_RATIO_MSB:`BITCLK_RATIO_LSB];       // [R02]
	assign no_pll_root_clock_select      = root_src_q[`ROOT_SEL_BIT];
	assign master_clock_spec_mode        = root_src_q[`SPEC_MODE_BIT];
	assign master_clock_ratio_code       =
		root_src_q[`MCLK_RATIO_MSB:`MCLK_RATIO_LSB];             // [R09]
	assign auto_on                       = ~i_auto_config_disable;

	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rate_ratio_q <= `RST_RATE_RATIO_CFG;                  // [R11]
			root_src_q   <= `RST_ROOT_SRC_CFG;                    // [R12]
			o_reg_rdata  <= 8'h00;
		end else begin
			if (i_reg_wr_en && i_reg_addr == `ADDR_RATE_RATIO_CFG)
				rate_ratio_q <= i_reg_wdata;
			if (i_reg_wr_en && i_reg_addr == `ADDR_ROOT_SRC_CFG)
				root_src_q <= i_reg_wdata & `ROOT_SRC_WR_MASK;    // [R12]
			case (i_reg_addr)
			`ADDR_RATE_RATIO_CFG: o_reg_rdata <= rate_ratio_q;
			`ADDR_DETECT_STATUS:  o_reg_rdata <= {det_rate_q, det_ratio_q}; // [R04] [R06]
			`ADDR_ROOT_SRC_CFG:   o_reg_rdata <= root_src_q;
			default:              o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// ---------------- lookup tables ----------------
	function [11:0] ratio_value;
		input [3:0] code;
		begin
			case (code)
			4'h0: ratio_value = 12'd16;
			4'h1: ratio_value = 12'd24;
			4'h2: ratio_value = 12'd32;
			4'h3: ratio_value = 12'd48;
			4'h4: ratio_value = 12'd64;
			4'h5: ratio_value = 12'd96;
			4'h6: ratio_value = 12'd128;
			4'h7: ratio_value = 12'd192;
			4'h8: ratio_value = 12'd256;
			4'h9: ratio_value = 12'd384;
			4'hA: ratio_value = 12'd512;
			4'hB: ratio_value = 12'd1024;
			4'hC: ratio_value = 12'd2048;
			default: ratio_value = 12'd0;
			endcase
		end
	endfunction

	// frame rate in units of 50 Hz, family 1 is the 44.1 kHz set
	function [13:0] rate_50hz;
		input [3:0] code;
		input       fam;
		begin
			case (code)
			4'h0: rate_50hz = fam ? 14'd147   : 14'd160;
			4'h1: rate_50hz = fam ? 14'd294   : 14'd320;
			4'h2: rate_50hz = fam ? 14'd441   : 14'd480;
			4'h3: rate_50hz = fam ? 14'd588   : 14'd640;
			4'h4: rate_50hz = fam ? 14'd882   : 14'd960;
			4'h5: rate_50hz = fam ? 14'd1764  : 14'd1920;
			4'h6: rate_50hz = fam ? 14'd3528  : 14'd3840;
			4'h7: rate_50hz = fam ? 14'd7056  : 14'd7680;
			4'h8: rate_50hz = fam ? 14'd14112 : 14'd15360;
			default: rate_50hz = 14'd0;
			endcase
		end
	endfunction

	// ---------------- pin sampling ----------------
	wire [2:0] pin_in;
	wire [2:0] pin_lvl;
	wire [2:0] pin_rise;
	wire [2:0] pin_fall;
	assign pin_in = {i_master_clock, i_frame_sync, i_bitclk};

	// a master clock faster than half the core clock aliases here
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			pin_edge_sync u_sync (
				.i_core_clk (i_core_clk),
				.i_resetn   (i_resetn),
				.i_pin      (pin_in[g]),
				.o_level    (pin_lvl[g]),
				.o_rise     (pin_rise[g]),
				.o_fall     (pin_fall[g])
			);
		end
	endgenerate

	// ---------------- root clock selection ----------------
	wire slave_root_mclk = ~i_bus_role_select & auto_on &
		i_auto_config_pll_disable & no_pll_root_clock_select;      // [R07] [R14]
	assign o_root_from_master_clock    = i_bus_role_select | slave_root_mclk;
	assign o_master_clock_ratio_in_use = i_bus_role_select | slave_root_mclk; // [R10]

	// ---------------- master generation ----------------
	reg  [27:0] acc_q;
	reg         bclk_q;
	reg         frame_sync_q;
	reg  [11:0] bit_q;
	reg  [27:0] gen_inc;
	reg  [27:0] gen_mod;
	reg  [27:0] gen_sum;
	reg  [27:0] gen_rem;
	wire [11:0] gen_ratio = ratio_value(programmed_bitclk_frame_ratio);
	wire [13:0] gen_rate  =
		rate_50hz(programmed_frame_rate, i_rate_family_select);    // [R15]
	// slave with auto configuration never reaches here, so fields are unused
	wire gen_en = i_bus_role_select &&
		programmed_frame_rate <= `RATE_CODE_MAX &&
		programmed_bitclk_frame_ratio <= `RATIO_CODE_MAX;          // [R03]

	always @* begin
		if (auto_on && master_clock_spec_mode) begin             // [R08]
			gen_inc = {15'd0, gen_ratio, 1'b0};
			case (master_clock_ratio_code)                       // [R09] [R10]
			3'd0: gen_mod = 28'd64;
			3'd1: gen_mod = 28'd256;
			3'd2: gen_mod = 28'd384;
			3'd3: gen_mod = 28'd512;
			3'd4: gen_mod = 28'd768;
			3'd5: gen_mod = 28'd1024;
			3'd6: gen_mod = 28'd1536;
			default: gen_mod = 28'd2304;
			endcase
		end else begin
			gen_inc = {1'b0, {14'h0000, gen_ratio} * {12'h000, gen_rate}, 1'b0};
			case (i_master_clock_frequency_select)               // [R16]
			3'd0: gen_mod = 28'd240000;
			3'd1: gen_mod = 28'd245760;
			3'd2: gen_mod = 28'd260000;
			3'd3: gen_mod = 28'd320000;
			3'd4: gen_mod = 28'd384000;
			3'd5: gen_mod = 28'd393600;
			3'd6: gen_mod = 28'd480000;
			default: gen_mod = 28'd491520;
			endcase
		end
		gen_sum = acc_q + gen_inc;
		gen_rem = gen_sum - gen_mod;
	end

	// fractional divider: one bit clock edge each time the phase wraps
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_q   <= 28'd0;
			bclk_q  <= 1'b0;
			frame_sync_q <= 1'b0;
			bit_q   <= 12'd0;
		end else if (!gen_en) begin
			acc_q   <= 28'd0;
			bclk_q  <= 1'b0;
			frame_sync_q <= 1'b0;
			bit_q   <= 12'd0;
		end else if (pin_rise[2]) begin
			if (gen_sum >= gen_mod) begin
				acc_q  <= (gen_rem >= gen_mod) ? 28'd0 : gen_rem;
				bclk_q <= ~bclk_q;
				if (bclk_q) begin
					// frame sync changes on the falling edge, one bit wide
					bit_q   <= (bit_q + 12'd1 >= gen_ratio) ? 12'd0
						: bit_q + 12'd1;
					frame_sync_q <= (bit_q + 12'd1 >= gen_ratio);
				end
			end else begin
				acc_q <= gen_sum;
			end
		end
	end

	assign o_bitclk          = bclk_q;
	assign o_frame_sync      = frame_sync_q;
	assign o_bitclk_oe_n     = ~i_bus_role_select;                 // [R13]
	assign o_frame_sync_oe_n = ~i_bus_role_select;                 // [R13]

	// ---------------- detection ----------------
	function [3:0] classify_rate;
		input [11:0] p;
		begin
			if (p >= `PER_C0_LO && p <= `PER_C0_HI) classify_rate = 4'h0;
			else if (p >= `PER_C1_LO && p <= `PER_C1_HI) classify_rate = 4'h1;
			else if (p >= `PER_C2_LO && p <= `PER_C2_HI) classify_rate = 4'h2;
			else if (p >= `PER_C3_LO && p <= `PER_C3_HI) classify_rate = 4'h3;
			else if (p >= `PER_C4_LO && p <= `PER_C4_HI) classify_rate = 4'h4;
			else if (p >= `PER_C5_LO && p <= `PER_C5_HI) classify_rate = 4'h5;
			else if (p >= `PER_C6_LO && p <= `PER_C6_HI) classify_rate = 4'h6;
			else if (p >= `PER_C7_LO && p <= `PER_C7_HI) classify_rate = 4'h7;
			else if (p >= `PER_C8_LO && p <= `PER_C8_HI) classify_rate = 4'h8;
			else classify_rate = `CODE_INVALID;                   // [R05]
		end
	endfunction

	function [3:0] classify_ratio;
		input [11:0] n;
		integer k;
		begin
			classify_ratio = `CODE_INVALID;                       // [R06]
			for (k = 0; k <= 12; k = k + 1)
				if (n == ratio_value(k[3:0]))
					classify_ratio = k[3:0];
		end
	endfunction

	// in master mode the own generated lines are measured
	wire bus_frame_rise = i_bus_role_select ? (pin_rise[2] & gen_en &
		bclk_q & (gen_sum >= gen_mod) & (bit_q + 12'd1 >= gen_ratio))
		: pin_rise[1];
	wire bus_bclk_rise  = i_bus_role_select ? (pin_rise[2] & gen_en &
		~bclk_q & (gen_sum >= gen_mod)) : pin_rise[0];

	reg  [11:0] per_q;
	reg  [11:0] bcnt_q;
	reg         seen_q;
	reg  [3:0]  cand_rate_q;
	reg  [3:0]  cand_ratio_q;
	wire [3:0]  new_rate  = classify_rate(per_q);
	wire [3:0]  new_ratio = classify_ratio(bcnt_q);

	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			per_q        <= 12'd0;
			bcnt_q       <= 12'd0;
			seen_q       <= 1'b0;
			cand_rate_q  <= `CODE_INVALID;
			cand_ratio_q <= `CODE_INVALID;
			det_rate_q   <= `CODE_INVALID;                         // [R04]
			det_ratio_q  <= `CODE_INVALID;                         // [R06]
		end else if (bus_frame_rise) begin
			per_q  <= 12'd1;
			bcnt_q <= {11'd0, bus_bclk_rise};
			seen_q <= 1'b1;
			if (seen_q) begin
				cand_rate_q  <= new_rate;
				cand_ratio_q <= new_ratio;
				// two matching frames in a row before publishing
				if (new_rate == cand_rate_q)
					det_rate_q <= new_rate;                        // [R17]
				if (new_ratio == cand_ratio_q)
					det_ratio_q <= new_ratio;                      // [R17]
			end
		end else if (per_q == `FRAME_TIMEOUT_CYC) begin
			seen_q       <= 1'b0;
			cand_rate_q  <= `CODE_INVALID;
			cand_ratio_q <= `CODE_INVALID;
			det_rate_q   <= `CODE_INVALID;                         // [R05]
			det_ratio_q  <= `CODE_INVALID;                         // [R06]
		end else begin
			per_q <= per_q + 12'd1;
			if (bus_bclk_rise && bcnt_q != `FRAME_TIMEOUT_CYC)
				bcnt_q <= bcnt_q + 12'd1;
		end
	end
endmodule

`default_nettype wire

// *** verification/audio_serial_clock_config_monitor_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module clk_monitor_checker (
	input wire logic       i_core_clk,
	input wire logic       i_resetn,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic       i_reg_wr_en,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       i_bus_role_select,
	input wire logic       i_auto_config_disable,
	input wire logic       i_auto_config_pll_disable,
	input wire logic       o_bitclk,
	input wire logic       o_bitclk_oe_n,
	input wire logic       o_frame_sync,
	input wire logic       o_frame_sync_oe_n,
	input wire logic       o_root_from_master_clock,
	input wire logic       o_master_clock_ratio_in_use
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	pin_dir_a: assert property (
		o_bitclk_oe_n == !i_bus_role_select && o_frame_sync_oe_n == o_bitclk_oe_n)
		else $error("pin direction does not follow role");
	slave_quiet_a: assert property (
		!i_bus_role_select [*3] |-> !o_bitclk && !o_frame_sync)
		else $error("generated clocks active in slave role");
	master_root_a: assert property (
		i_bus_role_select |-> o_root_from_master_clock)
		else $error("master clock not root in master role");
	ratio_use_a: assert property (
		o_master_clock_ratio_in_use == o_root_from_master_clock)
		else $error("master clock ratio use disagrees with root");
	root_gate_a: assert property (
		!i_bus_role_select && (i_auto_config_disable
		|| !i_auto_config_pll_disable) |-> !o_root_from_master_clock)
		else $error("root select active outside no-pll auto slave");
	rate_code_a: assert property (
		i_reg_addr == 8'h15 |=> o_reg_rdata[7:4] <= 4'h8
		|| o_reg_rdata[7:4] == 4'hF) else $error("reserved rate code seen");
	ratio_code_a: assert property (
		i_reg_addr == 8'h15 |=> o_reg_rdata[3:0] <= 4'hC
		|| o_reg_rdata[3:0] == 4'hF) else $error("reserved ratio code seen");
	src_low_a: assert property (
		i_reg_addr == 8'h16 |=> o_reg_rdata[2:0] == 3'h0)
		else $error("reserved source bits not zero");
	cfg_write_a: assert property (
		i_reg_wr_en && i_reg_addr == 8'h14 ##1 !i_reg_wr_en
		&& i_reg_addr == 8'h14 |=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("rate ratio write not read back");
endmodule
bind audio_serial_clock_config_monitor clk_monitor_checker u_chk (
	.i_core_clk                  (i_core_clk),
	.i_resetn                    (i_resetn),
	.i_reg_addr                  (i_reg_addr),
	.i_reg_wdata                 (i_reg_wdata),
	.i_reg_wr_en                 (i_reg_wr_en),
	.o_reg_rdata                 (o_reg_rdata),
	.i_bus_role_select           (i_bus_role_select),
	.i_auto_config_disable       (i_auto_config_disable),
	.i_auto_config_pll_disable   (i_auto_config_pll_disable),
	.o_bitclk                    (o_bitclk),
	.o_bitclk_oe_n               (o_bitclk_oe_n),
	.o_frame_sync                (o_frame_sync),
	.o_frame_sync_oe_n           (o_frame_sync_oe_n),
	.o_root_from_master_clock    (o_root_from_master_clock),
	.o_master_clock_ratio_in_use (o_master_clock_ratio_in_use)
);
`default_nettype wire

// *** verification/serial_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	input  wire logic        i_run,
	input  wire logic [15:0] i_half_ns,
	input  wire logic [11:0] i_bits,
	output var  logic        o_bitclk,
	output var  logic        o_frame_sync
);
	int n;
	initial begin
		o_bitclk = 1'b0;
		o_frame_sync = 1'b0;
		forever begin
			wait (i_run);
			for (n = 0; n < i_bits; n++) begin
				o_frame_sync = (n == 0);
				o_bitclk = 1'b0;
				#(i_half_ns);
				o_bitclk = 1'b1;
				#(i_half_ns);
			end
			// a stopped host parks its clock low, so no stray edge is seen
			if (!i_run)
				o_bitclk = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** verification/audio_serial_clock_config_monitor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module audio_serial_clock_config_monitor_tb_top;
	logic        i_core_clk, i_resetn, i_reg_wr_en, i_master_clock;
	logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic        i_bus_role_select, i_auto_config_disable;
	logic        i_auto_config_pll_disable, i_rate_family_select;
	logic [2:0]  i_master_clock_frequency_select;
	logic        o_bitclk, o_bitclk_oe_n, o_frame_sync, o_frame_sync_oe_n;
	logic        o_root_from_master_clock, o_master_clock_ratio_in_use;
	logic        host_run, host_bclk, host_fs;
	logic [15:0] host_half;
	logic [11:0] host_bits;
	wire         i_bitclk;
	wire         i_frame_sync;
	int          miscompares, num_checks, cycles;

	// whichever party owns the pin drives the wire
	assign i_bitclk = o_bitclk_oe_n ? host_bclk : o_bitclk;
	assign i_frame_sync = o_frame_sync_oe_n ? host_fs : o_frame_sync;

	audio_serial_clock_config_monitor u_dut (
		.i_core_clk                      (i_core_clk),
		.i_resetn                        (i_resetn),
		.i_reg_addr                      (i_reg_addr),
		.i_reg_wdata                     (i_reg_wdata),
		.i_reg_wr_en                     (i_reg_wr_en),
		.o_reg_rdata                     (o_reg_rdata),
		.i_bus_role_select               (i_bus_role_select),
		.i_auto_config_disable           (i_auto_config_disable),
		.i_auto_config_pll_disable       (i_auto_config_pll_disable),
		.i_rate_family_select            (i_rate_family_select),
		.i_master_clock_frequency_select (i_master_clock_frequency_select),
		.i_master_clock                  (i_master_clock),
		.i_bitclk                        (i_bitclk),
		.o_bitclk                        (o_bitclk),
		.o_bitclk_oe_n                   (o_bitclk_oe_n),
		.i_frame_sync                    (i_frame_sync),
		.o_frame_sync                    (o_frame_sync),
		.o_frame_sync_oe_n               (o_frame_sync_oe_n),
		.o_root_from_master_clock        (o_root_from_master_clock),
		.o_master_clock_ratio_in_use     (o_master_clock_ratio_in_use)
	);
	serial_host_model u_host (
		.i_run(host_run),
		.i_half_ns(host_half),
		.i_bits(host_bits),
		.o_bitclk(host_bclk),
		.o_frame_sync(host_fs)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	always #977 i_master_clock = ~i_master_clock;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			$display("mismatch at %0t: run did not finish in time", $time);
			tally_and_finish();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_core_clk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr_en = 1'b1;
		@(negedge i_core_clk);
		i_reg_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge i_core_clk);
		i_reg_addr = a;
		@(negedge i_core_clk);
		chk(o_reg_rdata, exp);
	endtask
	task automatic root_is(input logic exp);
		@(negedge i_core_clk);
		chk({6'h00, o_master_clock_ratio_in_use, o_root_from_master_clock},
			{6'h00, exp, exp});
	endtask

	task automatic regs_scenario;
		rd(8'h14, 8'h48);
		rd(8'h15, 8'hFF);
		rd(8'h16, 8'h10);
		wr(8'h16, 8'hFF);
		rd(8'h16, 8'hF8);
		wr(8'h15, 8'h00);
		rd(8'h15, 8'hFF);
		wr(8'h20, 8'hA5);
		rd(8'h20, 8'h00);
		wr(8'h14, 8'h23);
		rd(8'h14, 8'h23);
	endtask
	task automatic root_scenario;
		i_auto_config_pll_disable = 1'b1;
		root_is(1'b1);
		i_auto_config_disable = 1'b1;
		root_is(1'b0);
		i_auto_config_disable = 1'b0;
		i_auto_config_pll_disable = 1'b0;
		root_is(1'b0);
		i_auto_config_pll_disable = 1'b1;
		wr(8'h16, 8'h40);
		root_is(1'b0);
	endtask
	task automatic slave_scenario(input logic [15:0] half,
			input logic [11:0] bits, input int n, input logic [7:0] exp);
		host_half = half;
		host_bits = bits;
		host_run = 1'b1;
		idle(n);
		rd(8'h15, exp);
	endtask
	task automatic master_scenario;
		host_run = 1'b0;
		wr(8'h14, 8'h00);
		i_bus_role_select = 1'b1;
		idle(8000);
		rd(8'h15, 8'h00);
		chk({6'h00, o_bitclk_oe_n, o_frame_sync_oe_n}, 8'h00);
		root_is(1'b1);
	endtask
	// bench master clock is far below the nominal one, so the generated
	// 176.4 kHz frame lands in the slowest rate window
	task automatic absolute_scenario;
		i_rate_family_select = 1'b1;
		i_master_clock_frequency_select = 3'h0;
		wr(8'h16, 8'h00);
		wr(8'h14, 8'h62);
		idle(7000);
		rd(8'h15, 8'h02);
	endtask
	task automatic link_loss_scenario;
		host_run = 1'b0;
		idle(4300);
		rd(8'h15, 8'hFF);
	endtask

	initial begin
		i_resetn = 1'b0;
		i_reg_addr = 8'h00;
		i_reg_wdata = 8'h00;
		i_reg_wr_en = 1'b0;
		i_master_clock = 1'b0;
		i_bus_role_select = 1'b0;
		i_auto_config_disable = 1'b0;
		i_auto_config_pll_disable = 1'b0;
		i_rate_family_select = 1'b0;
		i_master_clock_frequency_select = 3'h2;
		host_run = 1'b0;
		host_half = 16'h0190;
		host_bits = 12'h010;
		idle(2);
		i_resetn = 1'b1;
		regs_scenario();
		root_scenario();
		slave_scenario(16'h0190, 12'h010, 800, 8'hF0);
		wr(8'h14, 8'hFF);
		slave_scenario(16'h0145, 12'h020, 1300, 8'h42);
		link_loss_scenario();
		master_scenario();
		absolute_scenario();
		tally_and_finish();
	end
endmodule
`default_nettype wire
